// File: rtl/flash_seq_pkg.sv
// Package for the flash erase, unlock and address-port block.
// Assumes a single 50 MHz system clock and a byte-wide CPU I/O bus.
package flash_seq_pkg;
  // I/O port addresses
  localparam logic [15:0] KEY_ADDR = 16'h00f5;
  localparam logic [15:0] DATA_ADDR = 16'h00f6;
  localparam logic [15:0] BASE_ADDR = 16'h00f7;
  localparam logic [15:0] CTRL_ADDR = 16'h00f8;
  localparam logic [15:0] FDIV_ADDR = 16'h00f9;
  localparam logic [15:0] PROT_ADDR = 16'h00fa;
  localparam logic [15:0] PAGE_ADDR = 16'h00fc;
  localparam logic [15:0] ROW_ADDR = 16'h00fd;
  localparam logic [15:0] COL_ADDR = 16'h00fe;
  localparam logic [15:0] ERASE_ADDR = 16'h00ff;
  // Key values
  localparam logic [7:0] KEY_FIRST = 8'hb6;
  localparam logic [7:0] KEY_SECOND = 8'h49;
  // Reset values and fields
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h88;
  localparam logic [7:0] FDIV_RST = 8'h01;
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CTRL_EN_BIT = 3;
  localparam int PAGE_INFO_BIT = 7;
  localparam int ERASE_PAGE_BIT = 0;
  localparam int ERASE_MASS_BIT = 1;
  localparam int ERASE_DONE_BIT = 7;
  // Erase times
  localparam int CLK_MHZ = 50;
  localparam int MASS_MS = 200;
  localparam int PAGE_MS = 10;
  localparam int MASS_CYCLES = MASS_MS * 1000 * CLK_MHZ;
  localparam int PAGE_CYCLES = PAGE_MS * 1000 * CLK_MHZ;
  // Array geometry: 128 pages x 8 rows x 256 columns
  localparam int ARRAY_BYTES = 262144;
  localparam int INFO_BYTES = 256;
  localparam int PAGE_BYTES = 2048;
  typedef enum logic [1:0] {LOCK_IDLE, LOCK_HALF, LOCK_OPEN} lock_e;
  typedef enum logic [1:0] {ER_IDLE, ER_MASS, ER_PAGE} erase_e;
  typedef struct packed {
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;
endpackage

// File: rtl/flash_erase_unlock_addr_port.sv
// Flash controller: erase sequencer, unlock keys and I/O address port.
// Assumes CPU requests are single-cycle strobes held while o_WAIT is high.
// Function
// - Erased bytes read back as all ones
// - Erase sequenced internally, CPU keeps running
// - Set done flag on erase completion
// - Stall CPU flash access during erase
// - Mass erase clears all, about 200ms
// - Page erase clears selected page, about 10ms
// - Information page reachable only through I/O
// - Info page erasable by mass or page
// - Key pair B6h then 49h unlocks
// - Reads and memory cycles do not disturb unlocking
// - Writing guarded register relocks both
// - Data port programs and reads addressed byte
// - Each data port access advances address
// - Upper bits place the flash window
// - Window hit suppresses external chip selects
// - SRAM decode beats flash window
// - Enable bit gates memory access only
// - Locked protect write forces all ones
`timescale 1ns/1ps
module flash_erase_unlock_addr_port #(
  parameter int MASS_COUNT = flash_seq_pkg::MASS_CYCLES,
  parameter int PAGE_COUNT = flash_seq_pkg::PAGE_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire flash_seq_pkg::cpu_req_s i_req,
  input wire logic i_sram_hit,
  output logic o_WAIT,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_flash_sel,
  output logic o_ext_cs_block,
  output logic o_busy
);
  logic [7:0] main_mem [flash_seq_pkg::ARRAY_BYTES];
  logic [7:0] info_mem [flash_seq_pkg::INFO_BYTES];
  flash_seq_pkg::lock_e lock;
  flash_seq_pkg::erase_e erase;
  logic [31:0] timer;
  logic [7:0] base_upper;
  logic [7:0] ctrl;
  logic [7:0] fdiv;
  logic [7:0] prot;
  logic [7:0] page;
  logic [2:0] row;
  logic [7:0] col;
  logic done;
  logic [18:0] clr_idx;

  // Decode of the request
  wire io_any = i_req.io_rd | i_req.io_wr;
  wire [15:0] io_a = i_req.addr[15:0];
  wire key_wr = i_req.io_wr && io_a == flash_seq_pkg::KEY_ADDR;
  wire data_acc = io_any && io_a == flash_seq_pkg::DATA_ADDR;
  wire fdiv_wr = i_req.io_wr && io_a == flash_seq_pkg::FDIV_ADDR;
  wire prot_wr = i_req.io_wr && io_a == flash_seq_pkg::PROT_ADDR;
  wire erase_wr = i_req.io_wr && io_a == flash_seq_pkg::ERASE_ADDR;
  wire info_sel = page[flash_seq_pkg::PAGE_INFO_BIT];
  wire in_window = i_req.addr[23:18] == base_upper[7:2];
  wire mem_any = i_req.mem_rd | i_req.mem_wr;
  wire mem_hit = mem_any && in_window && !i_sram_hit &&
    ctrl[flash_seq_pkg::CTRL_EN_BIT];
  wire flash_acc = mem_hit || data_acc;
  wire stall = flash_acc && erase != flash_seq_pkg::ER_IDLE;
  wire go = !stall;
  wire [17:0] io_off = {page[6:0], row, col};
  wire [17:0] mem_off = i_req.addr[17:0];
  wire [31:0] last_count = (erase == flash_seq_pkg::ER_MASS) ?
    32'(MASS_COUNT - 1) : 32'(PAGE_COUNT - 1);
  wire erase_end = erase != flash_seq_pkg::ER_IDLE && timer == last_count;
  wire [17:0] page_base = {page[6:0], 11'h000};
  // Command accepted from idle; busy rises with it so that busy and
  // the sequencer state never disagree by a cycle
  wire erase_start = erase == flash_seq_pkg::ER_IDLE && erase_wr &&
    (i_req.wdata[flash_seq_pkg::ERASE_MASS_BIT] ||
     i_req.wdata[flash_seq_pkg::ERASE_PAGE_BIT]);
  // Number of 256-byte rows in the main array
  wire [18:0] mass_rows =
    19'(flash_seq_pkg::ARRAY_BYTES / flash_seq_pkg::INFO_BYTES);

  // Outputs registered from the decode
  // Wait rises one cycle after a flash access meets a running erase
  // and repeats each cycle until the erase has ended
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      o_WAIT <= 1'b0;
      o_flash_sel <= 1'b0;
      o_ext_cs_block <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_WAIT <= stall;
      o_flash_sel <= mem_hit && go;
      o_ext_cs_block <= mem_hit;
      // Busy follows the sequencer state cycle for cycle
      o_busy <= erase_start ||
        (erase != flash_seq_pkg::ER_IDLE && !erase_end);
    end
  end

  // Unlock tracker: idle, first key seen, open
  // Reads and memory cycles never touch it, so a polling loop
  // between the two key writes cannot spoil the sequence
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      lock <= flash_seq_pkg::LOCK_IDLE;
    end else if (fdiv_wr || prot_wr) begin
      lock <= flash_seq_pkg::LOCK_IDLE;
    end else if (key_wr) begin
      if (lock == flash_seq_pkg::LOCK_IDLE &&
          i_req.wdata == flash_seq_pkg::KEY_FIRST) begin
        lock <= flash_seq_pkg::LOCK_HALF;
      end else if (lock == flash_seq_pkg::LOCK_HALF &&
                   i_req.wdata == flash_seq_pkg::KEY_SECOND) begin
        lock <= flash_seq_pkg::LOCK_OPEN;
      end else if (i_req.wdata == flash_seq_pkg::KEY_FIRST) begin
        lock <= flash_seq_pkg::LOCK_HALF;
      end else begin
        lock <= flash_seq_pkg::LOCK_IDLE;
      end
    end else if (i_req.io_wr && lock == flash_seq_pkg::LOCK_HALF) begin
      // another I/O write between the keys breaks the pair
      // an open lock stays open until a guarded register or the key port is written
      lock <= flash_seq_pkg::LOCK_IDLE;
    end
  end

  // Control and guarded registers
  // The divider takes a write only while open; a locked protect write
  // forces every block protected instead of being ignored
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      base_upper <= flash_seq_pkg::BASE_RST;
      ctrl <= flash_seq_pkg::CTRL_RST;
      fdiv <= flash_seq_pkg::FDIV_RST;
      prot <= flash_seq_pkg::PROT_RST;
    end else if (i_req.io_wr) begin
      if (io_a == flash_seq_pkg::BASE_ADDR) begin
        base_upper <= {i_req.wdata[7:2], 2'b00};
      end
      if (io_a == flash_seq_pkg::CTRL_ADDR) begin
        ctrl <= {i_req.wdata[7:5], 1'b0, i_req.wdata[3], 3'b000};
      end
      if (fdiv_wr && lock == flash_seq_pkg::LOCK_OPEN) begin
        fdiv <= i_req.wdata;
      end
      if (prot_wr) begin
        prot <= (lock == flash_seq_pkg::LOCK_OPEN) ? i_req.wdata :
          flash_seq_pkg::PROT_RST;
      end
    end
  end

  // Data port address with auto increment
  // Page, row and column form one 18-bit address; the carry runs from
  // column into row and page, while the info select bit stays put
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      page <= 8'h00;
      row <= 3'h0;
      col <= 8'h00;
    end else if (data_acc && go) begin
      {page[6:0], row, col} <= io_off + 18'h00001;
    end else if (i_req.io_wr) begin
      if (io_a == flash_seq_pkg::PAGE_ADDR) begin
        page <= i_req.wdata;
      end
      if (io_a == flash_seq_pkg::ROW_ADDR) begin
        row <= i_req.wdata[2:0];
      end
      if (io_a == flash_seq_pkg::COL_ADDR) begin
        col <= i_req.wdata;
      end
    end
  end

  // Erase sequencer
  // Timer counts cycles in the erase state; done drops on a new command
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      erase <= flash_seq_pkg::ER_IDLE;
      timer <= 32'h0;
      done <= 1'b0;
      clr_idx <= 19'h0;
    end else begin
      unique case (erase)
        flash_seq_pkg::ER_IDLE: begin
          timer <= 32'h0;
          clr_idx <= 19'h0;
          if (erase_wr && i_req.wdata[flash_seq_pkg::ERASE_MASS_BIT]) begin
            erase <= flash_seq_pkg::ER_MASS;
            done <= 1'b0;
          end else if (erase_wr &&
                       i_req.wdata[flash_seq_pkg::ERASE_PAGE_BIT]) begin
            erase <= flash_seq_pkg::ER_PAGE;
            done <= 1'b0;
          end else if (erase_wr && i_req.wdata[
                       flash_seq_pkg::ERASE_DONE_BIT]) begin
            done <= 1'b0;
          end
        end
        default: begin
          timer <= timer + 32'h1;
          if (clr_idx < 19'(flash_seq_pkg::ARRAY_BYTES)) begin
            clr_idx <= clr_idx + 19'h1;
          end
          if (erase_end) begin
            erase <= flash_seq_pkg::ER_IDLE;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Array contents: a mass erase clears a whole row per cycle, a page
  // erase one byte per cycle. Clearing by rows lets the main array and
  // the info page finish within any mass time of 1024 cycles or more,
  // so a shortened erase time still leaves no stale byte behind.
  always_ff @(posedge I_CLK_SYS) begin
    // mass erase covers main and info
    if (erase == flash_seq_pkg::ER_MASS && clr_idx < mass_rows) begin
      for (int k = 0; k < flash_seq_pkg::INFO_BYTES; k++) begin
        main_mem[{clr_idx[9:0], 8'(k)}] <= flash_seq_pkg::ERASED_BYTE;
        info_mem[k] <= flash_seq_pkg::ERASED_BYTE;
      end
    end
    if (erase == flash_seq_pkg::ER_PAGE &&
        clr_idx < 19'(flash_seq_pkg::PAGE_BYTES)) begin
      if (info_sel) begin
        if (clr_idx < 19'(flash_seq_pkg::INFO_BYTES)) begin
          info_mem[clr_idx[7:0]] <= flash_seq_pkg::ERASED_BYTE;
        end
      end else begin
        main_mem[page_base | 18'(clr_idx[10:0])] <=
          flash_seq_pkg::ERASED_BYTE;
      end
    end
    if (i_req.io_wr && data_acc && go) begin
      if (info_sel) begin
        info_mem[col] <= info_mem[col] & i_req.wdata;
      end else begin
        main_mem[io_off] <= main_mem[io_off] & i_req.wdata;
      end
    end
    if (i_req.mem_wr && mem_hit && go) begin
      main_mem[mem_off] <= main_mem[mem_off] & i_req.wdata;
    end
  end

  // Read return
  // Unmapped I/O reads and missed memory reads return zero
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= (i_req.io_rd || i_req.mem_rd) && go;
      if (i_req.io_rd && data_acc && go) begin
        o_rdata <= info_sel ? info_mem[col] : main_mem[io_off];
      end else if (i_req.mem_rd && mem_hit && go) begin
        o_rdata <= main_mem[mem_off];
      end else if (i_req.io_rd) begin
        unique case (io_a)
          flash_seq_pkg::BASE_ADDR: o_rdata <= base_upper;
          flash_seq_pkg::CTRL_ADDR: o_rdata <= ctrl;
          flash_seq_pkg::FDIV_ADDR: o_rdata <= fdiv;
          flash_seq_pkg::PROT_ADDR: o_rdata <= prot;
          flash_seq_pkg::PAGE_ADDR: o_rdata <= page;
          flash_seq_pkg::ROW_ADDR: o_rdata <= {5'h00, row};
          flash_seq_pkg::COL_ADDR: o_rdata <= col;
          flash_seq_pkg::ERASE_ADDR: o_rdata <= {done, 7'h00};
          default: o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule

// File: testbench/flash_seq_asserts.sv
// Checker for the flash erase, unlock and address-port block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module flash_seq_asserts #(
  parameter int MASS_COUNT = 10,
  parameter int PAGE_COUNT = 10
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire flash_seq_pkg::cpu_req_s i_req,
  input wire logic i_sram_hit,
  input wire logic o_WAIT,
  input wire logic o_rvalid,
  input wire logic o_flash_sel,
  input wire logic o_ext_cs_block,
  input wire logic o_busy
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // Request decode
  wire logic mem = i_req.mem_rd | i_req.mem_wr;
  wire logic io = i_req.io_rd | i_req.io_wr;
  wire logic rd = i_req.io_rd | i_req.mem_rd;
  wire logic data_acc = io && i_req.addr[15:0] == flash_seq_pkg::DATA_ADDR;
  wire logic cmd = i_req.io_wr && (i_req.wdata[0] | i_req.wdata[1]) &&
    i_req.addr[15:0] == flash_seq_pkg::ERASE_ADDR;
  // Length of the current erase run
  int run;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !o_busy) run <= 0;
    else run <= run + 1;
  end
  sequence erase_cmd;
    cmd && !o_busy;
  endsequence
  sequence stalled_acc;
    (data_acc && o_busy) ##1 o_busy;
  endsequence
  AST_RVALID_CAUSE: assert property (o_rvalid |-> $past(rd) && !o_WAIT)
    else $error("read answer without a read");
  AST_WAIT_BUSY: assert property (o_WAIT |-> $past(o_busy))
    else $error("wait without erase running");
  AST_STALL: assert property (stalled_acc |-> o_WAIT)
    else $error("flash access not stalled");
  AST_SRAM_WINS: assert property (mem && i_sram_hit |=> !o_ext_cs_block)
    else $error("flash answered over sram");
  AST_SEL_BLOCKS: assert property (o_flash_sel |-> o_ext_cs_block)
    else $error("flash served with chip selects free");
  AST_IO_NO_SEL: assert property (io |=> !o_flash_sel && !o_ext_cs_block)
    else $error("io cycle took memory path");
  AST_ERASE_RUN: assert property (erase_cmd |=> o_busy [*8])
    else $error("erase not running after command");
  AST_ERASE_LEN: assert property ($fell(o_busy) && !$past(I_RST) |->
    run == PAGE_COUNT || run == MASS_COUNT)
    else $error("erase run length wrong");
endmodule
bind flash_erase_unlock_addr_port flash_seq_asserts #(
  .MASS_COUNT(MASS_COUNT), .PAGE_COUNT(PAGE_COUNT)) chk_u (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_req(i_req),
  .i_sram_hit(i_sram_hit), .o_WAIT(o_WAIT), .o_rvalid(o_rvalid),
  .o_flash_sel(o_flash_sel), .o_ext_cs_block(o_ext_cs_block),
  .o_busy(o_busy));

// File: testbench/cpu_host_model.sv
// CPU host model issuing I/O and memory cycles to the flash block.
// Drives just after the clock edge; strobes drop to zero on release, other lines show inverted values.
`timescale 1ns/1ps
module cpu_host_model (
  input wire logic I_CLK_SYS,
  input wire logic o_WAIT,
  input wire logic [7:0] o_rdata,
  input wire logic o_flash_sel,
  input wire logic o_ext_cs_block,
  output flash_seq_pkg::cpu_req_s req,
  output logic sram_hit
);
  logic [7:0] rd;
  logic sel, blk, stalled;
  initial begin
    req = '0;
    sram_hit = 1'b0;
  end
  // One cycle: drive, hold through stalls, take answer, release
  task cyc(input logic [3:0] k, input logic [23:0] a,
    input logic [7:0] d, input logic h);
    @(posedge I_CLK_SYS);
    #1;
    {req.io_rd, req.io_wr, req.mem_rd, req.mem_wr} = k;
    req.addr = a;
    req.wdata = d;
    sram_hit = h;
    stalled = 1'b0;
    @(posedge I_CLK_SYS);
    #1;
    while (o_WAIT !== 1'b0) begin
      stalled = 1'b1;
      @(posedge I_CLK_SYS);
      #1;
    end
    rd = o_rdata;
    sel = o_flash_sel;
    blk = o_ext_cs_block;
    {req.io_rd, req.io_wr, req.mem_rd, req.mem_wr} = 4'h0;
    req.addr = ~a;
    req.wdata = ~d;
    sram_hit = ~h;
  endtask
endmodule

// File: testbench/test_flash_erase_unlock_addr_port.sv
// Bench for the flash erase, unlock and address-port block.
// Shortened erase counts; the host model makes every request.
`timescale 1ns/1ps
module test_flash_erase_unlock_addr_port;
  localparam logic [3:0] IOR = 4'h8;
  localparam logic [3:0] IOW = 4'h4;
  localparam logic [3:0] MRD = 4'h2;
  logic I_CLK_SYS = 1'b0;
  logic I_RST = 1'b1;
  flash_seq_pkg::cpu_req_s req;
  logic sram_hit, o_WAIT, o_rvalid, o_flash_sel, o_ext_cs_block, o_busy;
  logic [7:0] o_rdata;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  initial forever #10 I_CLK_SYS = ~I_CLK_SYS;
  flash_erase_unlock_addr_port #(.MASS_COUNT(3000), .PAGE_COUNT(2100)) dut_u (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_req(req),
    .i_sram_hit(sram_hit), .o_WAIT(o_WAIT), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_flash_sel(o_flash_sel),
    .o_ext_cs_block(o_ext_cs_block), .o_busy(o_busy));
  cpu_host_model host_u (.I_CLK_SYS(I_CLK_SYS), .o_WAIT(o_WAIT),
    .o_rdata(o_rdata), .o_flash_sel(o_flash_sel),
    .o_ext_cs_block(o_ext_cs_block), .req(req), .sram_hit(sram_hit));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host_u.cyc(IOW, {16'h0000, a}, d, 1'b0);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_u.cyc(IOR, {16'h0000, a}, 8'h00, 1'b0);
    chk(host_u.rd, e);
    chk({7'h00, o_rvalid}, 8'h01);
  endtask
  task mem_chk(input logic [23:0] a, input logic h, input logic [1:0] e);
    host_u.cyc(MRD, a, 8'h00, h);
    chk({6'h00, host_u.sel, host_u.blk}, {6'h00, e});
  endtask
  task t_unlock;
    rd_chk(8'hf7, 8'h00);
    wr(8'hf9, 8'h22);
    rd_chk(8'hf9, 8'h01);
    wr(8'hf5, 8'hb6);
    rd_chk(8'hf7, 8'h00);
    host_u.cyc(MRD, 24'h000010, 8'h00, 1'b0);
    wr(8'hf5, 8'h49);
    wr(8'hf9, 8'h22);
    rd_chk(8'hf9, 8'h22);
    wr(8'hf9, 8'h33);
    rd_chk(8'hf9, 8'h22);
    wr(8'hfa, 8'h00);
    rd_chk(8'hfa, 8'hff);
    wr(8'hf5, 8'hb6);
    wr(8'hf5, 8'h49);
    wr(8'hfa, 8'h0f);
    rd_chk(8'hfa, 8'h0f);
    wr(8'hfa, 8'h00);
    rd_chk(8'hfa, 8'hff);
    wr(8'hf9, 8'h55);
    rd_chk(8'hf9, 8'h22);
    wr(8'hf5, 8'hb6);
    wr(8'hf5, 8'h11);
    wr(8'hf5, 8'h49);
    wr(8'hf9, 8'h44);
    rd_chk(8'hf9, 8'h22);
    wr(8'hf5, 8'hb6);
    wr(8'hf7, 8'h00);
    wr(8'hf5, 8'h49);
    wr(8'hf9, 8'h66);
    rd_chk(8'hf9, 8'h22);
  endtask
  task erase_rd(input logic [7:0] pg, input logic [7:0] cmd);
    wr(8'hfc, pg);
    wr(8'hfd, 8'h00);
    wr(8'hfe, 8'h00);
    wr(8'hff, cmd);
    rd_chk(8'hfd, 8'h00);
    chk({6'h00, host_u.stalled, o_busy}, 8'h01);
    host_u.cyc(IOR, 24'h0000f6, 8'h00, 1'b0);
    chk({7'h00, host_u.stalled}, 8'h01);
    host_u.cyc(IOR, 24'h0000ff, 8'h00, 1'b0);
    chk(host_u.rd & 8'h80, 8'h80);
    wr(8'hff, 8'h80);
    host_u.cyc(IOR, 24'h0000ff, 8'h00, 1'b0);
    chk(host_u.rd & 8'h80, 8'h00);
  endtask
  task t_page;
    erase_rd(8'h00, 8'h01);
    chk({7'h00, o_busy}, 8'h00);
    wr(8'hfe, 8'h00);
    rd_chk(8'hf6, 8'hff);
    wr(8'hf6, 8'ha5);
    wr(8'hfe, 8'h01);
    rd_chk(8'hf6, 8'ha5);
    erase_rd(8'h80, 8'h01);
    rd_chk(8'hf6, 8'hff);
    wr(8'hf6, 8'h3c);
    wr(8'hfe, 8'h02);
    rd_chk(8'hf6, 8'h3c);
    wr(8'hfc, 8'h00);
    wr(8'hfe, 8'h01);
    rd_chk(8'hf6, 8'ha5);
  endtask
  task t_window;
    wr(8'hf7, 8'h07);
    rd_chk(8'hf7, 8'h04);
    mem_chk(24'h040001, 1'b0, 2'h3);
    chk(host_u.rd, 8'ha5);
    mem_chk(24'h040001, 1'b1, 2'h0);
    mem_chk(24'h000001, 1'b0, 2'h0);
    wr(8'hf8, 8'h00);
    mem_chk(24'h040001, 1'b0, 2'h0);
    wr(8'hfe, 8'h01);
    rd_chk(8'hf6, 8'ha5);
  endtask
  task t_mass;
    erase_rd(8'h00, 8'h02);
    wr(8'hfc, 8'h7f);
    wr(8'hfd, 8'h07);
    wr(8'hfe, 8'hff);
    rd_chk(8'hf6, 8'hff);
    wr(8'hfc, 8'h80);
    wr(8'hfe, 8'h02);
    rd_chk(8'hf6, 8'hff);
  endtask
  task tally_and_finish;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge I_CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge I_CLK_SYS);
    #1;
    I_RST = 1'b0;
    t_unlock;
    t_page;
    t_window;
    t_mass;
    tally_and_finish;
  end
endmodule
